//--- logic/sysctl.sv
// System clock, reset, wake-up and power mode control with its registers.
// Notes on behaviour
// - PLL multiplier accepts every integer setting from 1 to 32.
// - PLL output divider divides by 2, 4, 8 or 16.
// - Any chip reset leaves the PLL off and bypassed.
// - Filtered reset pin or watchdog resets the chip and starts wake timer.
// - Internal reset holds until pin, oscillator, timer and flash are ready.
// - Released reset leaves registers at defaults, core starts at zero.
// - Leaving power-down always waits for the wake-up timer.
// - Nine external interrupt pins combine onto four interrupt lines.
// - Each external interrupt pin may be enabled to end power-down.
// - Vector area at zero maps to flash or to static RAM.
// - Idle stops the core until reset or interrupt; peripherals run.
// - Power-down stops oscillator and clocks, holding all state.
// - Power-down ends only by reset or clockless external interrupt.
// - Each peripheral has its own power enable.
// - Peripheral clock runs at full, half or quarter processor rate.
// - Peripheral clock divider resets to quarter rate.
// - PLL keeps running through idle when it was running.
// - Processor clock is the oscillator unless PLL runs and is connected.
//
// The register offsets and the plain strobed port were left to the implementer.
module sysctl #(
  parameter int PERIPH_N = 16,
  parameter int WAKE_LEN = sysctl_pkg::WAKE_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [sysctl_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [sysctl_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [sysctl_pkg::DATA_W-1:0] reg_rdata,
  input wire logic ext_reset_n,
  input wire logic wdt_reset,
  input wire logic osc_ready,
  input wire logic flash_init_done,
  input wire logic pll_lock,
  input wire logic irq_pending,
  input wire logic [sysctl_pkg::EINT_N-1:0] eint_pin,
  output logic core_rst,
  output logic osc_enable,
  output logic pll_power,
  output logic [sysctl_pkg::MSEL_W-1:0] pll_msel,
  output logic [sysctl_pkg::PSEL_W-1:0] pll_psel,
  output logic cclk_sel_pll,
  output logic cpu_clk_en,
  output logic pclk_en,
  output logic [PERIPH_N-1:0] periph_power,
  output logic vector_sram,
  output logic [sysctl_pkg::IRQ_N-1:0] eint_irq
);

  if (PERIPH_N < 1 || PERIPH_N > sysctl_pkg::DATA_W) begin : g_bad_periph
    $error("PERIPH_N must lie between 1 and the data width");
  end

  localparam int EN = sysctl_pkg::EINT_N;
  localparam int RW = sysctl_pkg::ROUTE_W;

  typedef struct packed {
    logic pll_en;
    logic pll_con;
    logic [sysctl_pkg::MSEL_W-1:0] msel;
    logic [sysctl_pkg::PSEL_W-1:0] psel;
    logic [1:0] pbdiv;
    logic vec_sram;
    logic [PERIPH_N-1:0] pconp;
    logic [EN-1:0] eint_mode;
    logic [EN-1:0] eint_pol;
    logic [EN-1:0] eint_wake;
    logic [EN-1:0] eint_flag;
    logic [EN-1:0] eint_prev;
    logic [EN*RW-1:0] route;
    logic [1:0] rsrc;
    sysctl_pkg::pmode_t pmode;
    logic pin_rst;
    logic core_rst;
    logic osc_en;
    logic pll_pwr;
    logic cclk_pll;
    logic cpu_en;
    logic pclk_en;
    logic [1:0] pdiv_cnt;
    logic [sysctl_pkg::IRQ_N-1:0] irq;
    logic [sysctl_pkg::DATA_W-1:0] rdata;
  } st_t;

  st_t st_ff;
  st_t nxt_st;
  logic wake_done;
  logic glitch_done;
  logic chip_rst_req;
  logic [EN-1:0] eint_act;
  logic wake_hit;

  assign chip_rst_req = st_ff.pin_rst | wdt_reset;
  assign eint_act = ~(eint_pin ^ st_ff.eint_pol);
  assign wake_hit = |(eint_act & st_ff.eint_wake);

  // Filters glitches off the external reset pin.
  count_timer #(
    .W(sysctl_pkg::TIMER_W),
    .LEN(sysctl_pkg::GLITCH_CYCLES)
  ) u_glitch (
    .sys_clk(sys_clk),
    .rst(rst),
    .start((~ext_reset_n) == st_ff.pin_rst),
    .run(1'b1),
    .done(glitch_done)
  );

  // Counts oscillator clocks after reset or power-down.
  count_timer #(
    .W(sysctl_pkg::TIMER_W),
    .LEN(WAKE_LEN)
  ) u_wake (
    .sys_clk(sys_clk),
    .rst(rst),
    .start(chip_rst_req || st_ff.pmode == sysctl_pkg::pm_pdown),
    .run(osc_ready),
    .done(wake_done)
  );

  always_comb begin
    logic wr_ok;
    logic [1:0] lim;
    logic [EN-1:0] set_flag;
    nxt_st = st_ff;
    wr_ok = reg_wr && !st_ff.core_rst;
    lim = sysctl_pkg::PDIV_LIM_QUARTER;
    set_flag = '0;

    if (glitch_done && (~ext_reset_n) != st_ff.pin_rst) begin
      nxt_st.pin_rst = ~ext_reset_n;
    end

    // Reset sources are sticky; a new source wins over a clear.
    if (wr_ok && reg_addr == sysctl_pkg::OFS_RSRC) begin
      nxt_st.rsrc = st_ff.rsrc & ~reg_wdata[1:0];
    end
    if (st_ff.pin_rst) begin
      nxt_st.rsrc[sysctl_pkg::RSRC_PIN_BIT] = 1'b1;
    end
    if (wdt_reset) begin
      nxt_st.rsrc[sysctl_pkg::RSRC_WDT_BIT] = 1'b1;
    end

    if (wr_ok) begin
      case (reg_addr)
        sysctl_pkg::OFS_PLL_CTRL: begin
          nxt_st.pll_en = reg_wdata[sysctl_pkg::PLL_EN_BIT];
          nxt_st.pll_con = reg_wdata[sysctl_pkg::PLL_CON_BIT];
          nxt_st.msel = reg_wdata[sysctl_pkg::MSEL_LSB +:
            sysctl_pkg::MSEL_W];
          nxt_st.psel = reg_wdata[sysctl_pkg::PSEL_LSB +:
            sysctl_pkg::PSEL_W];
        end
        sysctl_pkg::OFS_PBDIV: nxt_st.pbdiv = reg_wdata[1:0];
        sysctl_pkg::OFS_MEMMAP: nxt_st.vec_sram = reg_wdata[0];
        sysctl_pkg::OFS_PCONP: begin
          nxt_st.pconp = reg_wdata[PERIPH_N-1:0];
        end
        sysctl_pkg::OFS_EINT_MODE: nxt_st.eint_mode = reg_wdata[EN-1:0];
        sysctl_pkg::OFS_EINT_POL: nxt_st.eint_pol = reg_wdata[EN-1:0];
        sysctl_pkg::OFS_EINT_WAKE: begin
          nxt_st.eint_wake = reg_wdata[EN-1:0];
        end
        sysctl_pkg::OFS_EINT_FLAG: begin
          nxt_st.eint_flag = st_ff.eint_flag & ~reg_wdata[EN-1:0];
        end
        sysctl_pkg::OFS_EINT_ROUTE: nxt_st.route = reg_wdata[EN*RW-1:0];
        default: begin
        end
      endcase
    end

    // Edge mode catches a rising active level, level mode sets the flag on every active cycle.
    set_flag = eint_act & (~st_ff.eint_mode | ~st_ff.eint_prev);
    nxt_st.eint_flag = nxt_st.eint_flag | set_flag;
    nxt_st.eint_prev = eint_act;
    nxt_st.irq = '0;
    for (int i = 0; i < EN; i++) begin
      if (st_ff.eint_flag[i]) begin
        nxt_st.irq[st_ff.route[i*RW +: RW]] = 1'b1;
      end
    end

    case (st_ff.pmode)
      sysctl_pkg::pm_run: begin
        if (wr_ok && reg_addr == sysctl_pkg::OFS_PCON) begin
          if (reg_wdata[sysctl_pkg::PCON_PD_BIT]) begin
            nxt_st.pmode = sysctl_pkg::pm_pdown;
          end else if (reg_wdata[sysctl_pkg::PCON_IDLE_BIT]) begin
            nxt_st.pmode = sysctl_pkg::pm_idle;
          end
        end
      end
      sysctl_pkg::pm_idle: begin
        if (irq_pending || st_ff.irq != '0) begin
          nxt_st.pmode = sysctl_pkg::pm_run;
        end
      end
      sysctl_pkg::pm_pdown: begin
        if (wake_hit) begin
          nxt_st.pmode = sysctl_pkg::pm_wake;
        end
      end
      sysctl_pkg::pm_wake: begin
        if (wake_done && osc_ready) begin
          nxt_st.pmode = sysctl_pkg::pm_run;
        end
      end
      default: nxt_st.pmode = sysctl_pkg::pm_run;
    endcase

    if (chip_rst_req) begin
      nxt_st.core_rst = 1'b1;
    end else if (st_ff.core_rst && osc_ready && wake_done &&
                 flash_init_done) begin
      nxt_st.core_rst = 1'b0;
    end

    // Held reset restores every control to its default value.
    if (nxt_st.core_rst) begin
      nxt_st.pll_en = 1'b0;
      nxt_st.pll_con = 1'b0;
      nxt_st.msel = '0;
      nxt_st.psel = '0;
      nxt_st.pbdiv = sysctl_pkg::PBDIV_RST;
      nxt_st.vec_sram = sysctl_pkg::MAP_FLASH;
      nxt_st.pconp = '1;
      nxt_st.eint_mode = '0;
      nxt_st.eint_pol = '0;
      nxt_st.eint_wake = '0;
      nxt_st.eint_flag = '0;
      nxt_st.route = '0;
      nxt_st.irq = '0;
      nxt_st.pmode = sysctl_pkg::pm_run;
    end

    // Power-down stops oscillator and PLL; idle leaves the PLL alone.
    nxt_st.osc_en = nxt_st.pmode != sysctl_pkg::pm_pdown;
    nxt_st.pll_pwr = nxt_st.pll_en &&
      nxt_st.pmode != sysctl_pkg::pm_pdown;
    nxt_st.cclk_pll = nxt_st.pll_con && nxt_st.pll_pwr &&
      st_ff.pll_pwr && pll_lock;
    nxt_st.cpu_en = nxt_st.pmode == sysctl_pkg::pm_run &&
      !nxt_st.core_rst;

    case (nxt_st.pbdiv)
      sysctl_pkg::PB_FULL: lim = sysctl_pkg::PDIV_LIM_FULL;
      sysctl_pkg::PB_HALF: lim = sysctl_pkg::PDIV_LIM_HALF;
      default: lim = sysctl_pkg::PDIV_LIM_QUARTER;
    endcase
    if (nxt_st.pmode == sysctl_pkg::pm_pdown ||
        nxt_st.pmode == sysctl_pkg::pm_wake) begin
      nxt_st.pclk_en = 1'b0;
      nxt_st.pdiv_cnt = '0;
    end else begin
      nxt_st.pclk_en = st_ff.pdiv_cnt == '0;
      nxt_st.pdiv_cnt = (st_ff.pdiv_cnt >= lim) ? 2'h0 :
        st_ff.pdiv_cnt + 2'h1;
    end

    nxt_st.rdata = '0;
    if (reg_rd) begin
      case (reg_addr)
        sysctl_pkg::OFS_PLL_CTRL: begin
          nxt_st.rdata[8:0] = {st_ff.psel, st_ff.msel, st_ff.pll_con,
            st_ff.pll_en};
        end
        sysctl_pkg::OFS_PLL_STAT: begin
          nxt_st.rdata[8:0] = {st_ff.psel, st_ff.msel, st_ff.pll_con,
            st_ff.pll_en};
          nxt_st.rdata[sysctl_pkg::STAT_LOCK_BIT] = pll_lock;
          nxt_st.rdata[sysctl_pkg::STAT_CONN_BIT] = st_ff.cclk_pll;
        end
        sysctl_pkg::OFS_PBDIV: nxt_st.rdata[1:0] = st_ff.pbdiv;
        sysctl_pkg::OFS_MEMMAP: nxt_st.rdata[0] = st_ff.vec_sram;
        sysctl_pkg::OFS_PCON: begin
          nxt_st.rdata[sysctl_pkg::PCON_IDLE_BIT] =
            st_ff.pmode == sysctl_pkg::pm_idle;
          nxt_st.rdata[sysctl_pkg::PCON_PD_BIT] =
            st_ff.pmode == sysctl_pkg::pm_pdown ||
            st_ff.pmode == sysctl_pkg::pm_wake;
        end
        sysctl_pkg::OFS_PCONP: nxt_st.rdata[PERIPH_N-1:0] = st_ff.pconp;
        sysctl_pkg::OFS_EINT_MODE: nxt_st.rdata[EN-1:0] = st_ff.eint_mode;
        sysctl_pkg::OFS_EINT_POL: nxt_st.rdata[EN-1:0] = st_ff.eint_pol;
        sysctl_pkg::OFS_EINT_WAKE: nxt_st.rdata[EN-1:0] = st_ff.eint_wake;
        sysctl_pkg::OFS_EINT_FLAG: nxt_st.rdata[EN-1:0] = st_ff.eint_flag;
        sysctl_pkg::OFS_EINT_ROUTE: nxt_st.rdata[EN*RW-1:0] = st_ff.route;
        sysctl_pkg::OFS_RSRC: nxt_st.rdata[1:0] = st_ff.rsrc;
        default: nxt_st.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
      st_ff.pbdiv <= sysctl_pkg::PBDIV_RST;
      st_ff.pconp <= '1;
      st_ff.pmode <= sysctl_pkg::pm_run;
      st_ff.pin_rst <= 1'b1;
      st_ff.core_rst <= 1'b1;
      st_ff.osc_en <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign reg_rdata = st_ff.rdata;
  assign core_rst = st_ff.core_rst;
  assign osc_enable = st_ff.osc_en;
  assign pll_power = st_ff.pll_pwr;
  assign pll_msel = st_ff.msel;
  assign pll_psel = st_ff.psel;
  assign cclk_sel_pll = st_ff.cclk_pll;
  assign cpu_clk_en = st_ff.cpu_en;
  assign pclk_en = st_ff.pclk_en;
  assign periph_power = st_ff.pconp;
  assign vector_sram = st_ff.vec_sram;
  assign eint_irq = st_ff.irq;

  property p_pll_off_in_reset;
    @(posedge sys_clk) disable iff (rst)
      core_rst |-> !pll_power && !cclk_sel_pll;
  endproperty
  a_pll_off_in_reset: assert property (p_pll_off_in_reset)
    else $error("PLL active during reset");

  property p_pll_needs_lock;
    @(posedge sys_clk) disable iff (rst)
      cclk_sel_pll |-> $past(pll_lock) && pll_power;
  endproperty
  a_pll_needs_lock: assert property (p_pll_needs_lock)
    else $error("PLL selected without lock");

  property p_reset_release;
    @(posedge sys_clk) disable iff (rst)
      $fell(core_rst) |-> $past(flash_init_done) && $past(osc_ready) &&
        $past(wake_done) && !$past(st_ff.pin_rst) && !$past(wdt_reset);
  endproperty
  a_reset_release: assert property (p_reset_release)
    else $error("Reset released too early");

  property p_wdt_resets;
    @(posedge sys_clk) disable iff (rst)
      wdt_reset |=> core_rst ##1 (core_rst && !wake_done);
  endproperty
  a_wdt_resets: assert property (p_wdt_resets)
    else $error("Watchdog did not reset chip");

  property p_pbdiv_default;
    @(posedge sys_clk) disable iff (rst)
      core_rst |-> st_ff.pbdiv == sysctl_pkg::PB_QUARTER;
  endproperty
  a_pbdiv_default: assert property (p_pbdiv_default)
    else $error("Peripheral divider not at quarter");

  property p_quarter_spacing;
    @(posedge sys_clk) disable iff (rst)
      pclk_en && st_ff.pbdiv == sysctl_pkg::PB_QUARTER |=> !pclk_en;
  endproperty
  a_quarter_spacing: assert property (p_quarter_spacing)
    else $error("Peripheral clock too fast");

  property p_pdown_gated;
    @(posedge sys_clk) disable iff (rst)
      st_ff.pmode == sysctl_pkg::pm_pdown |->
        !osc_enable && !cpu_clk_en && !pclk_en && !pll_power;
  endproperty
  a_pdown_gated: assert property (p_pdown_gated)
    else $error("Clock running in power-down");

  property p_wake_timer;
    @(posedge sys_clk) disable iff (rst)
      $past(st_ff.pmode) == sysctl_pkg::pm_wake &&
        st_ff.pmode == sysctl_pkg::pm_run && !core_rst |->
        $past(wake_done) && $past(osc_ready);
  endproperty
  a_wake_timer: assert property (p_wake_timer)
    else $error("Woke before wake-up timer");

  property p_wake_source;
    @(posedge sys_clk) disable iff (rst)
      st_ff.pmode == sysctl_pkg::pm_pdown && wake_hit && !chip_rst_req
        |=> st_ff.pmode == sysctl_pkg::pm_wake ##1 osc_enable;
  endproperty
  a_wake_source: assert property (p_wake_source)
    else $error("Enabled pin did not wake");

  property p_idle_exit;
    @(posedge sys_clk) disable iff (rst)
      st_ff.pmode == sysctl_pkg::pm_idle && irq_pending && !chip_rst_req
        |=> cpu_clk_en;
  endproperty
  a_idle_exit: assert property (p_idle_exit)
    else $error("Interrupt did not end idle");

  property p_vector_map;
    @(posedge sys_clk) disable iff (rst)
      reg_wr && reg_addr == sysctl_pkg::OFS_MEMMAP && !core_rst &&
        !chip_rst_req |=> vector_sram == $past(reg_wdata[0]);
  endproperty
  a_vector_map: assert property (p_vector_map)
    else $error("Vector map not updated");

endmodule

//--- logic/sysctl_pkg.sv
// Constants for the system clock, reset and power control block.
package sysctl_pkg;

  localparam int CLK_PERIOD_NS = 10;
  localparam int WAKE_TIME_NS = 20000;
  localparam int WAKE_CYCLES =
    (WAKE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GLITCH_TIME_NS = 100;
  localparam int GLITCH_CYCLES =
    (GLITCH_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMER_W = 16;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] OFS_PLL_CTRL = 8'h00;
  localparam logic [7:0] OFS_PLL_STAT = 8'h04;
  localparam logic [7:0] OFS_PBDIV = 8'h08;
  localparam logic [7:0] OFS_MEMMAP = 8'h0c;
  localparam logic [7:0] OFS_PCON = 8'h10;
  localparam logic [7:0] OFS_PCONP = 8'h14;
  localparam logic [7:0] OFS_EINT_MODE = 8'h18;
  localparam logic [7:0] OFS_EINT_POL = 8'h1c;
  localparam logic [7:0] OFS_EINT_WAKE = 8'h20;
  localparam logic [7:0] OFS_EINT_FLAG = 8'h24;
  localparam logic [7:0] OFS_EINT_ROUTE = 8'h28;
  localparam logic [7:0] OFS_RSRC = 8'h2c;

  localparam int PLL_EN_BIT = 0;
  localparam int PLL_CON_BIT = 1;
  localparam int MSEL_LSB = 2;
  localparam int MSEL_W = 5;
  localparam int PSEL_LSB = 7;
  localparam int PSEL_W = 2;
  localparam int STAT_LOCK_BIT = 9;
  localparam int STAT_CONN_BIT = 10;

  localparam logic [1:0] PB_QUARTER = 2'h0;
  localparam logic [1:0] PB_FULL = 2'h1;
  localparam logic [1:0] PB_HALF = 2'h2;
  localparam logic [1:0] PBDIV_RST = PB_QUARTER;
  localparam logic [1:0] PDIV_LIM_FULL = 2'h0;
  localparam logic [1:0] PDIV_LIM_HALF = 2'h1;
  localparam logic [1:0] PDIV_LIM_QUARTER = 2'h3;

  localparam logic MAP_FLASH = 1'b0;
  localparam logic MAP_SRAM = 1'b1;

  localparam int PCON_IDLE_BIT = 0;
  localparam int PCON_PD_BIT = 1;
  localparam int RSRC_PIN_BIT = 0;
  localparam int RSRC_WDT_BIT = 1;

  localparam int EINT_N = 9;
  localparam int IRQ_N = 4;
  localparam int ROUTE_W = 2;

  typedef enum logic [1:0] {pm_run, pm_idle, pm_pdown, pm_wake} pmode_t;

endpackage

//--- logic/count_timer.sv
// Reloadable down counter that flags when its count has run out.
module count_timer #(
  parameter int W = 16,
  parameter int LEN = 10
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic start,
  input wire logic run,
  output logic done
);

  if (LEN < 1 || LEN >= (1 << W)) begin : g_bad_len
    $error("count_timer length does not fit its counter");
  end

  localparam logic [W-1:0] LOAD = W'(LEN);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic done;
  } tmr_t;

  tmr_t st_ff;
  tmr_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (start) begin
      nxt_st.cnt = LOAD;
    end else if (run && st_ff.cnt != '0) begin
      nxt_st.cnt = st_ff.cnt - 1'b1;
    end
    nxt_st.done = (nxt_st.cnt == '0);
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_ff <= '{cnt: LOAD, done: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign done = st_ff.done;

endmodule

//--- verification/sysctl_far_model.sv
// Oscillator, PLL and flash controller models that drive the status inputs.
module sysctl_far_model #(
  parameter int OSC_DLY = 6,
  parameter int LOCK_DLY = 12,
  parameter int FLASH_DLY = 40
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic osc_enable,
  input wire logic pll_power,
  output logic osc_ready,
  output logic pll_lock,
  output logic flash_init_done
);
  timeunit 1ns;
  timeprecision 1ps;
  int osc_cnt;
  int lock_cnt;
  int flash_cnt;
  // Each source reports ready only after its own start-up delay.
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      osc_cnt <= 0;
      lock_cnt <= 0;
      flash_cnt <= 0;
    end else begin
      osc_cnt <= osc_enable ? osc_cnt + int'(osc_cnt < OSC_DLY) : 0;
      lock_cnt <= (pll_power && osc_ready) ?
        lock_cnt + int'(lock_cnt < LOCK_DLY) : 0;
      flash_cnt <= flash_cnt + int'(flash_cnt < FLASH_DLY);
    end
  end
  assign osc_ready = osc_cnt >= OSC_DLY;
  assign pll_lock = lock_cnt >= LOCK_DLY;
  assign flash_init_done = flash_cnt >= FLASH_DLY;
endmodule

//--- verification/testbench.sv
// Self-checking bench for the clock, reset and power control block.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WL = 4;
  localparam int FD = 40;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic ext_reset_n = 1'b1;
  logic wdt_reset = 1'b0;
  logic irq_pending = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic [8:0] eint_pin = 9'h1ff;
  logic [31:0] rnd = 32'h9fa6;
  logic osc_ready, flash_init_done, pll_lock, core_rst, osc_enable;
  logic pll_power, cclk_sel_pll, cpu_clk_en, pclk_en, vector_sram;
  logic [31:0] reg_rdata, rdat, ms;
  logic [4:0] pll_msel;
  logic [1:0] pll_psel;
  logic [15:0] periph_power;
  logic [3:0] eint_irq;
  logic [17:0] route;
  int mismatches = 0;
  int n_tests = 0;
  int n, hi;
  int per_q[$] = '{4, 1, 2, 4};

  sysctl #(.PERIPH_N(16), .WAKE_LEN(WL)) dut_u (
    .sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .ext_reset_n, .wdt_reset, .osc_ready, .flash_init_done, .pll_lock,
    .irq_pending, .eint_pin, .core_rst, .osc_enable, .pll_power,
    .pll_msel, .pll_psel, .cclk_sel_pll, .cpu_clk_en, .pclk_en,
    .periph_power, .vector_sram, .eint_irq);

  sysctl_far_model #(.FLASH_DLY(FD)) far_u (
    .sys_clk, .rst, .osc_enable, .pll_power, .osc_ready, .pll_lock,
    .flash_init_done);

  always #5 sys_clk = ~sys_clk;

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic chk_val(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic end_of_test();
    $display("Comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic tk(input int c);
    repeat (c) @(posedge sys_clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    rdat = reg_rdata;
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] a,
    input logic [31:0] m, input logic [31:0] e);
    rd(a);
    chk_val(nm, e, rdat & m);
  endtask

  task automatic boot(input string nm, input int mn);
    n = 0;
    while (core_rst !== 1'b0 && n < 500) begin
      tk(1);
      n++;
    end
    chk_val(nm, 1, 32'(n >= mn && n < 500));
  endtask

  task automatic pcount();
    hi = 0;
    tk(4);
    repeat (32) begin
      hi += int'(pclk_en === 1'b1);
      tk(1);
    end
  endtask

  task automatic pin_low(input int c);
    @(posedge sys_clk);
    ext_reset_n <= 1'b0;
    repeat (c) @(posedge sys_clk);
    ext_reset_n <= 1'b1;
  endtask

  initial begin
    repeat (15) @(posedge sys_clk);
    #1;
    chk_val("rst_core", 1, 32'(core_rst));
    chk_val("rst_pll", 0, 32'({pll_power, cclk_sel_pll}));
    @(posedge sys_clk);
    rst <= 1'b0;
    boot("por_boot", FD);
    rd_chk("rsrc_por", sysctl_pkg::OFS_RSRC, 32'h3, 32'h1);
    wr(sysctl_pkg::OFS_RSRC, 32'h3);
    rd_chk("stat_rst", sysctl_pkg::OFS_PLL_STAT, 32'h7ff, 32'h0);
    rd_chk("pbdiv_rst", sysctl_pkg::OFS_PBDIV, 32'h3, 32'h0);
    rd_chk("map_rst", sysctl_pkg::OFS_MEMMAP, 32'h1, 32'h0);
    rd_chk("unmapped", 8'h30, 32'hffffffff, 32'h0);
    pcount();
    chk_val("pclk_rst", 8, hi);
    for (int k = 0; k < 4; k++) begin
      wr(sysctl_pkg::OFS_PBDIV, 32'(k));
      pcount();
      chk_val("pclk", 32 / per_q[k], hi);
    end
    wr(sysctl_pkg::OFS_MEMMAP, 32'h1);
    chk_val("vec_sram", 1, 32'(vector_sram));
    rnd = xs(rnd);
    wr(sysctl_pkg::OFS_PCONP, rnd);
    chk_val("pconp", 32'(rnd[15:0]), 32'(periph_power));
    wr(sysctl_pkg::OFS_PCONP, 32'hffff);
    for (int i = 0; i < 4; i++) begin
      rnd = xs(rnd);
      ms = (i == 0) ? 32'h0 : (i == 1) ? 32'h1f : 32'(rnd[4:0]);
      wr(sysctl_pkg::OFS_PLL_CTRL, (32'(i) << 7) | (ms << 2));
      chk_val("msel", ms, 32'(pll_msel));
      chk_val("psel", 32'(i), 32'(pll_psel));
      chk_val("sel_off", 0, 32'(cclk_sel_pll));
    end
    wr(sysctl_pkg::OFS_PLL_CTRL, 32'h95);
    n = 0;
    do begin
      rd(sysctl_pkg::OFS_PLL_STAT);
      n++;
    end while (rdat[9] !== 1'b1 && n < 50);
    chk_val("lock", 1, 32'(rdat[9]));
    wr(sysctl_pkg::OFS_PLL_CTRL, 32'h97);
    tk(1);
    chk_val("sel_on", 1, 32'(cclk_sel_pll));
    wr(sysctl_pkg::OFS_PCON, 32'h1);
    tk(8);
    chk_val("idle_cpu", 0, 32'(cpu_clk_en));
    chk_val("idle_pll", 3, 32'({pll_power, cclk_sel_pll}));
    rd_chk("pcon_idle", sysctl_pkg::OFS_PCON, 32'h3, 32'h1);
    pcount();
    chk_val("idle_pclk", 8, hi);
    @(posedge sys_clk);
    irq_pending <= 1'b1;
    tk(3);
    chk_val("idle_end", 1, 32'(cpu_clk_en));
    @(posedge sys_clk);
    irq_pending <= 1'b0;
    wr(sysctl_pkg::OFS_EINT_MODE, 32'h1ff);
    rnd = xs(rnd);
    route = rnd[17:0];
    wr(sysctl_pkg::OFS_EINT_ROUTE, 32'(route));
    for (int p = 0; p < 9; p++) begin
      @(posedge sys_clk);
      eint_pin <= ~(9'h1 << p);
      @(posedge sys_clk);
      eint_pin <= 9'h1ff;
      tk(3);
      chk_val("eint", 32'h1 << route[2*p +: 2], 32'(eint_irq));
      wr(sysctl_pkg::OFS_EINT_FLAG, 32'h1 << p);
      tk(1);
      chk_val("eint_clr", 0, 32'(eint_irq));
    end
    wr(sysctl_pkg::OFS_EINT_POL, 32'h1);
    tk(2);
    chk_val("eint_pol", 32'h1 << route[1:0], 32'(eint_irq));
    wr(sysctl_pkg::OFS_EINT_POL, 32'h0);
    wr(sysctl_pkg::OFS_EINT_FLAG, 32'h1);
    wr(sysctl_pkg::OFS_EINT_MODE, 32'h0);
    wr(sysctl_pkg::OFS_EINT_WAKE, 32'h10);
    wr(sysctl_pkg::OFS_PCON, 32'h3);
    tk(2);
    chk_val("pd", 0, 32'({osc_enable, pll_power, cpu_clk_en}));
    chk_val("pd_hold", 1, 32'(vector_sram));
    chk_val("pd_sel", 0, 32'(cclk_sel_pll));
    @(posedge sys_clk);
    eint_pin <= 9'h1f7;
    tk(6);
    chk_val("pd_stay", 0, 32'(osc_enable));
    @(posedge sys_clk);
    eint_pin <= 9'h1ef;
    n = 0;
    while (cpu_clk_en !== 1'b1 && n < 200) begin
      tk(1);
      n++;
    end
    chk_val("pd_wake", 1, 32'(n >= WL && n < 200));
    chk_val("osc_back", 1, 32'(osc_enable));
    @(posedge sys_clk);
    eint_pin <= 9'h1ff;
    wr(sysctl_pkg::OFS_EINT_FLAG, 32'h1ff);
    @(posedge sys_clk);
    wdt_reset <= 1'b1;
    @(posedge sys_clk);
    wdt_reset <= 1'b0;
    #1;
    chk_val("wdt_rst", 1, 32'(core_rst));
    boot("wdt_boot", WL - 1);
    rd_chk("rsrc_wdt", sysctl_pkg::OFS_RSRC, 32'h3, 32'h2);
    rd_chk("pbdiv_def", sysctl_pkg::OFS_PBDIV, 32'h3, 32'h0);
    rd_chk("stat_def", sysctl_pkg::OFS_PLL_STAT, 32'h1ff, 32'h0);
    chk_val("map_def", 0, 32'(vector_sram));
    wr(sysctl_pkg::OFS_RSRC, 32'h3);
    pin_low(5);
    tk(3);
    chk_val("glitch", 0, 32'(core_rst));
    pin_low(20);
    #1;
    chk_val("pin_rst", 1, 32'(core_rst));
    boot("pin_boot", sysctl_pkg::GLITCH_CYCLES + WL);
    rd_chk("rsrc_pin", sysctl_pkg::OFS_RSRC, 32'h3, 32'h1);
    end_of_test();
  end

  // The whole sequence needs under a thousand cycles; this cuts a hang short at 10000.
  initial begin
    #100000;
    mismatches++;
    end_of_test();
  end
endmodule
